/* File: rtl/alarm_pkg.sv */
// Purpose: Shared constants for the slave configuration and link alarm checker.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets marked idx are register indices; byte address is four times the index.
package alarm_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [11:0] EEP_STATUS_IDX   = 12'h502;
	localparam logic [11:0] IBUF_START_IDX   = 12'h818;
	localparam logic [11:0] IBUF_LEN_IDX     = 12'h81a;
	localparam logic [11:0] IBUF_CTRL_IDX    = 12'h81c;
	localparam logic [11:0] LINK_TMO_IDX     = 12'h900;
	localparam logic [11:0] CFG_IDX          = 12'h901;
	localparam logic [11:0] ALARM_IDX        = 12'h902;
	localparam logic [11:0] CMD_IDX          = 12'h903;
	localparam logic [11:0] MBX_IDX          = 12'h904;
	localparam logic [11:0] OUT_BUF_IDX      = 12'h905;
	localparam logic [11:0] IDENT_IDX        = 12'h906;
	localparam logic [11:0] IDENT_STORED_IDX = 12'h907;
	// ----------------------------------------------------------------
	// Field positions and limits
	// ----------------------------------------------------------------
	localparam int          CTRL_MODE_LO   = 2;
	localparam logic [1:0]  CTRL_MODE_OK   = 2'h0;
	localparam int          EEP_ERR_LO     = 11;
	localparam int          EEP_ERR_HI     = 14;
	localparam logic [15:0] ADDR_MIN       = 16'h1000;
	localparam logic [15:0] ADDR_MAX       = 16'h2fff;
	localparam logic [7:0]  MAP_MAX_BYTES  = 8'h20;
	localparam logic [15:0] TMO_RESET      = 16'h0000;
	// ----------------------------------------------------------------
	// Status codes
	// ----------------------------------------------------------------
	localparam logic [15:0] CODE_NONE      = 16'h0000;
	localparam logic [15:0] CODE_SM3       = 16'h001e;
	localparam logic [15:0] CODE_TXMAP     = 16'h0024;
	localparam logic [15:0] CODE_RXMAP     = 16'h0025;
	localparam logic [15:0] CODE_EEP       = 16'h0051;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ         = 125000000;
	localparam int          MS_CYCLES      = CLK_HZ / 1000;
	// ----------------------------------------------------------------
	// Slave states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT
	} slave_state_e;
	// Indicator patterns.
	localparam logic [1:0]  LED_OFF        = 2'h0;
	localparam logic [1:0]  LED_BLINK      = 2'h1;
	localparam logic [1:0]  LED_DOUBLE     = 2'h2;
	localparam logic [1:0]  LED_FLICKER    = 2'h3;
endpackage

/* File: rtl/alarm_checker.sv */
// Purpose: Checks input buffer setup, mapping sizes, link loss and config EEPROM.
// Assumes: The master programs all settings before asking for PreOP to SafeOP.
// Notes:   The slave state is held here and forced back when an alarm fires.

// How it works
// - Input buffer start outside range raises alarm.
// - Receive and transmit buffer overlap is invalid.
// - Mailbox overlapping process buffers is invalid.
// - Odd buffer start address is invalid.
// - Buffer length must equal TxPDO size.
// - Control bits 3..2 must be 00.
// - Check at PreOP-SafeOP and after; PreOP, 001Eh.
// - TxPDO mapping over 32 bytes: PreOP, 0024h.
// - RxPDO mapping over 32 bytes: PreOP, 0025h.
// - Port lost for timeout after PreOP entry.
// - Link loss in PreOP..Boot: Init, 0000h.
// - Timeout signed 16-bit ms; zero disables.
// - Timeout resets to zero.
// - Only locally seen link loss raises alarm.
// - Identity mismatch in any state: Init, 0051h.
// - Bad EEPROM access completion raises alarm.
// - EEPROM status bits 11..14 raise alarm.
// - EEPROM alarm cannot be cleared.
module alarm_checker #(
	parameter int MS_CNT   = alarm_pkg::MS_CYCLES,
	parameter int BLINK_CNT = 25000000
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link and EEPROM events from pins.
	input  wire logic [1:0]  port_lost,
	input  wire logic        eep_access_bad,
	// Slave state and alarm outputs.
	output logic      [2:0]  slave_state,
	output logic      [15:0] al_status_code,
	output logic             err_led
);
	import alarm_pkg::*;

	// Refuse counts that the tick and flicker logic cannot serve.
	if (MS_CNT < 1 || BLINK_CNT < 8) begin : g_count_check
		$error("alarm_checker: counts too small");
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [15:0] eep_status_reg;
	logic [15:0] ibuf_start_reg;
	logic [15:0] ibuf_len_reg;
	logic [7:0]  ibuf_ctrl_reg;
	logic [15:0] link_tmo_reg;
	logic [15:0] tx_map_reg;
	logic [15:0] rx_map_reg;
	logic [15:0] mbx_start_reg;
	logic [15:0] mbx_end_reg;
	logic [15:0] obuf_start_reg;
	logic [15:0] obuf_len_reg;
	logic [31:0] ident_reg;
	logic [31:0] ident_stored_reg;
	logic [3:0]  alarm_reg;
	logic [15:0] code_reg;
	slave_state_e state_reg;

	logic        wr_en;
	logic        rd_en;
	logic [11:0] idx;
	logic        hit;
	logic        req_preop;
	logic        req_safeop;
	logic        req_op;
	logic        req_boot;
	logic        req_init;
	logic        clear_req;

	assign idx     = paddr[13:2];
	assign wr_en   = psel && penable && pwrite && hit;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr[15:14] == 2'h0) && (paddr[1:0] == 2'h0) &&
		(idx == EEP_STATUS_IDX || idx == IBUF_START_IDX || idx == IBUF_LEN_IDX ||
		 idx == IBUF_CTRL_IDX || (idx >= LINK_TMO_IDX && idx <= IDENT_STORED_IDX));
	assign pslverr = psel && penable && !hit;

	// Command word: bit0 clear, bits 4..1 request Init/PreOP/SafeOP/OP, bit5 Boot.
	assign clear_req  = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[0];
	assign req_init   = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[1];
	assign req_preop  = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[2];
	assign req_safeop = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[3];
	assign req_op     = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[4];
	assign req_boot   = wr_en && idx == CMD_IDX && pstrb[0] && pwdata[5];

	// Plain writable settings; paired and identity registers take all 32 bits, gated by the low strobes only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eep_status_reg   <= 16'h0000;
			ibuf_start_reg   <= 16'h0000;
			ibuf_len_reg     <= 16'h0000;
			ibuf_ctrl_reg    <= 8'h00;
			tx_map_reg       <= 16'h0000;
			rx_map_reg       <= 16'h0000;
			mbx_start_reg    <= 16'h0000;
			mbx_end_reg      <= 16'h0000;
			obuf_start_reg   <= 16'h0000;
			obuf_len_reg     <= 16'h0000;
			ident_reg        <= 32'h0000_0000;
			ident_stored_reg <= 32'h0000_0000;
		end else if (wr_en && pstrb[0] && pstrb[1]) begin
			case (idx)
				EEP_STATUS_IDX:   eep_status_reg <= pwdata[15:0];
				IBUF_START_IDX:   ibuf_start_reg <= pwdata[15:0];
				IBUF_LEN_IDX:     ibuf_len_reg   <= pwdata[15:0];
				IBUF_CTRL_IDX:    ibuf_ctrl_reg  <= pwdata[7:0];
				CFG_IDX: begin
					tx_map_reg <= pwdata[15:0];
					rx_map_reg <= pwdata[31:16];
				end
				MBX_IDX: begin
					mbx_start_reg <= pwdata[15:0];
					mbx_end_reg   <= pwdata[31:16];
				end
				OUT_BUF_IDX: begin
					obuf_start_reg <= pwdata[15:0];
					obuf_len_reg   <= pwdata[31:16];
				end
				IDENT_IDX:        ident_reg        <= pwdata;
				IDENT_STORED_IDX: ident_stored_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// Timeout setting starts at zero so link supervision is off after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_tmo_reg <= TMO_RESET;
		end else if (wr_en && idx == LINK_TMO_IDX && pstrb[0] && pstrb[1]) begin
			link_tmo_reg <= {1'b0, pwdata[14:0]};
		end
	end

	// Read mux decodes paddr[13:2] only; unmapped indices read zero along with pslverr.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr[13:2])
				EEP_STATUS_IDX:   prdata <= {16'h0000, eep_status_reg};
				IBUF_START_IDX:   prdata <= {16'h0000, ibuf_start_reg};
				IBUF_LEN_IDX:     prdata <= {16'h0000, ibuf_len_reg};
				IBUF_CTRL_IDX:    prdata <= {24'h000000, ibuf_ctrl_reg};
				LINK_TMO_IDX:     prdata <= {16'h0000, link_tmo_reg};
				CFG_IDX:          prdata <= {rx_map_reg, tx_map_reg};
				ALARM_IDX:        prdata <= {code_reg, 9'h000, state_reg, alarm_reg};
				MBX_IDX:          prdata <= {mbx_end_reg, mbx_start_reg};
				OUT_BUF_IDX:      prdata <= {obuf_len_reg, obuf_start_reg};
				IDENT_IDX:        prdata <= ident_reg;
				IDENT_STORED_IDX: prdata <= ident_stored_reg;
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Buffer setup and mapping size checks
	// ----------------------------------------------------------------
	logic [16:0] ibuf_end;
	logic [16:0] obuf_end;
	logic        addr_bad;
	logic        ovl_bad;
	logic        mbx_bad;
	logic        odd_bad;
	logic        len_bad;
	logic        ctrl_bad;
	logic        sm3_bad;
	logic        tx_big;
	logic        rx_big;

	assign ibuf_end = {1'b0, ibuf_start_reg} + {1'b0, ibuf_len_reg};
	assign obuf_end = {1'b0, obuf_start_reg} + {1'b0, obuf_len_reg};
	assign addr_bad = ibuf_start_reg < ADDR_MIN ||
		ibuf_end > {1'b0, ADDR_MAX} + 17'h00001;
	assign ovl_bad  = {1'b0, ibuf_start_reg} < obuf_end &&
		{1'b0, obuf_start_reg} < ibuf_end;
	assign mbx_bad  = ({1'b0, ibuf_start_reg} <= {1'b0, mbx_end_reg} &&
		{1'b0, mbx_start_reg} < ibuf_end) ||
		({1'b0, obuf_start_reg} <= {1'b0, mbx_end_reg} &&
		{1'b0, mbx_start_reg} < obuf_end);
	assign odd_bad  = ibuf_start_reg[0] || obuf_start_reg[0];
	assign len_bad  = ibuf_len_reg != tx_map_reg;
	assign ctrl_bad = ibuf_ctrl_reg[CTRL_MODE_LO+1:CTRL_MODE_LO] != CTRL_MODE_OK;
	assign sm3_bad  = addr_bad || ovl_bad || mbx_bad || odd_bad || len_bad || ctrl_bad;
	assign tx_big   = tx_map_reg > {8'h00, MAP_MAX_BYTES};
	assign rx_big   = rx_map_reg > {8'h00, MAP_MAX_BYTES};

	// ----------------------------------------------------------------
	// Pin synchronisers and link loss timing
	// ----------------------------------------------------------------
	logic [2:0] sync0;
	logic [2:0] sync1;
	logic [2:0] synce;
	logic [1:0] lost;
	logic       eep_bad_lvl;

	// Three stages; a level is taken once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync0       <= 3'h0;
			sync1       <= 3'h0;
			synce       <= 3'h0;
			lost        <= 2'h0;
			eep_bad_lvl <= 1'b0;
		end else begin
			sync0 <= {sync0[1:0], port_lost[0]};
			sync1 <= {sync1[1:0], port_lost[1]};
			synce <= {synce[1:0], eep_access_bad};
			if (sync0[2] == sync0[1]) lost[0] <= sync0[2];
			if (sync1[2] == sync1[1]) lost[1] <= sync1[2];
			if (synce[2] == synce[1]) eep_bad_lvl <= synce[2];
		end
	end

	logic [1:0]  excl_reg;
	logic [31:0] tick_cnt;
	logic [15:0] ms_cnt0;
	logic [15:0] ms_cnt1;
	logic        ms_tick;
	logic        enter_preop;
	logic        link_fire;
	logic        sup_state;

	assign ms_tick   = tick_cnt == 32'(MS_CNT - 1);
	assign sup_state = state_reg != ST_INIT;
	// Only this slave's own port pins feed the timer; no downstream inference.
	assign link_fire = sup_state && link_tmo_reg != 16'h0000 &&
		((ms_cnt0 >= link_tmo_reg) || (ms_cnt1 >= link_tmo_reg));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= ms_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end

	// A port already lost at PreOP entry is excluded until it recovers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			excl_reg <= 2'h0;
			ms_cnt0  <= 16'h0000;
			ms_cnt1  <= 16'h0000;
		end else begin
			if (enter_preop) begin
				excl_reg <= lost;
			end else begin
				excl_reg <= excl_reg & lost;
			end
			if (!lost[0] || excl_reg[0] || !sup_state) ms_cnt0 <= 16'h0000;
			else if (ms_tick && ms_cnt0 != 16'hffff) ms_cnt0 <= ms_cnt0 + 16'h0001;
			if (!lost[1] || excl_reg[1] || !sup_state) ms_cnt1 <= 16'h0000;
			else if (ms_tick && ms_cnt1 != 16'hffff) ms_cnt1 <= ms_cnt1 + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// EEPROM check
	// ----------------------------------------------------------------
	logic eep_fire;
	assign eep_fire = ident_reg != ident_stored_reg || eep_bad_lvl ||
		(|eep_status_reg[EEP_ERR_HI:EEP_ERR_LO]);

	// ----------------------------------------------------------------
	// Slave state and alarm latches
	// ----------------------------------------------------------------
	// alarm_reg: 0 setup/tx map/rx map (blink), 1 rx map, 2 link loss, 3 eeprom.
	logic to_safeop;
	logic cfg_fire;
	logic run_fire;
	assign to_safeop   = req_safeop && state_reg == ST_PREOP;
	assign enter_preop = req_preop && state_reg == ST_INIT && !eep_fire && alarm_reg == 4'h0;
	assign run_fire    = (state_reg == ST_SAFEOP || state_reg == ST_OP) && sm3_bad;
	assign cfg_fire    = (to_safeop && (sm3_bad || tx_big || rx_big)) || run_fire;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_INIT;
			alarm_reg <= 4'h0;
			code_reg  <= CODE_NONE;
		end else begin
			// Set wins over clear; the EEPROM bit ignores clear entirely.
			alarm_reg[3] <= alarm_reg[3] || eep_fire;
			alarm_reg[2] <= (alarm_reg[2] && !clear_req) || link_fire;
			alarm_reg[1] <= (alarm_reg[1] && !clear_req) || (to_safeop && rx_big);
			alarm_reg[0] <= (alarm_reg[0] && !clear_req) || cfg_fire;
			if (eep_fire) begin
				state_reg <= ST_INIT;
				code_reg  <= CODE_EEP;
			end else if (link_fire) begin
				state_reg <= ST_INIT;
				code_reg  <= CODE_NONE;
			end else if (cfg_fire) begin
				state_reg <= ST_PREOP;
				if (sm3_bad) code_reg <= CODE_SM3;
				else if (tx_big) code_reg <= CODE_TXMAP;
				else code_reg <= CODE_RXMAP;
			end else if (req_init) begin
				state_reg <= ST_INIT;
			end else if (enter_preop) begin
				state_reg <= ST_PREOP;
			end else if (to_safeop && alarm_reg[2:0] == 3'h0) begin
				state_reg <= ST_SAFEOP;
			end else if (req_op && state_reg == ST_SAFEOP) begin
				state_reg <= ST_OP;
			end else if (req_boot && state_reg == ST_INIT && alarm_reg == 4'h0) begin
				state_reg <= ST_BOOT;
			end
		end
	end

	assign slave_state    = state_reg;
	assign al_status_code = code_reg;

	// ----------------------------------------------------------------
	// Error indicator
	// ----------------------------------------------------------------
	logic [31:0] led_cnt;
	logic [2:0]  phase;
	logic [1:0]  pattern;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_cnt <= 32'h0000_0000;
			phase   <= 3'h0;
			err_led <= 1'b0;
		end else begin
			if (led_cnt == 32'(BLINK_CNT - 1)) begin
				led_cnt <= 32'h0000_0000;
				phase   <= phase + 3'h1;
			end else begin
				led_cnt <= led_cnt + 32'h0000_0001;
			end
			// Flicker uses a fast counter bit; double flash lights phases 0 and 2.
			case (pattern)
				LED_BLINK:   err_led <= phase[0];
				LED_DOUBLE:  err_led <= phase == 3'h0 || phase == 3'h2;
				LED_FLICKER: err_led <= led_cnt[2];
				default:     err_led <= 1'b0;
			endcase
		end
	end
	assign pattern = alarm_reg[3] ? LED_FLICKER : alarm_reg[2] ? LED_DOUBLE :
		(|alarm_reg[1:0]) ? LED_BLINK : LED_OFF;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	eep_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_reg[3] |=> alarm_reg[3]) else $error("eeprom alarm dropped");
	eep_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		eep_fire |=> state_reg == ST_INIT && code_reg == CODE_EEP)
		else $error("eeprom fault not handled");
	sm3_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		run_fire && !eep_fire && !link_fire |=> state_reg == ST_PREOP && code_reg == CODE_SM3)
		else $error("setup fault not handled");
	tx_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		to_safeop && tx_big && !sm3_bad && !eep_fire && !link_fire |=> code_reg == CODE_TXMAP)
		else $error("tx map fault code wrong");
	rx_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		to_safeop && rx_big && !tx_big && !sm3_bad && !eep_fire && !link_fire
		|=> code_reg == CODE_RXMAP && alarm_reg[1]) else $error("rx map fault wrong");
	link_init_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_fire && !eep_fire |=> state_reg == ST_INIT && alarm_reg[2])
		else $error("link loss not handled");
	tmo_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_tmo_reg == 16'h0000 && !alarm_reg[2] |=> !alarm_reg[2]) else $error("zero timeout fired");
	ctrl_chk_a: assert property (@(posedge pclk) disable iff (!presetn)
		ibuf_ctrl_reg[3:2] != 2'h0 && (state_reg == ST_SAFEOP || state_reg == ST_OP) && !eep_fire
		&& !link_fire |=> state_reg == ST_PREOP) else $error("control bits not checked");
	odd_chk_a: assert property (@(posedge pclk) disable iff (!presetn)
		to_safeop && ibuf_start_reg[0] && !eep_fire && !link_fire
		|=> state_reg == ST_PREOP && code_reg == CODE_SM3) else $error("odd start not checked");
endmodule

/* File: test/apb_master_model.sv */
// Purpose: APB master that stands in for the fieldbus master on the register bus.
// Assumes: The slave answers with pready; no fixed latency is assumed here.
// Notes:   Every signal changes by non-blocking assignment just after a rising edge.
module apb_master_model (
	// Clock.
	input  wire logic        pclk,
	// Request side.
	output logic             psel    = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite  = 1'b0,
	output logic      [15:0] paddr   = 16'h0000,
	output logic      [31:0] pwdata  = 32'h0000_0000,
	output logic      [3:0]  pstrb   = 4'hf,
	// Answer side.
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// One transfer: setup, then access until pready is seen high.
	// ----------------------------------------------------------------
	// The request is held whole until the answering edge, so a slow slave is safe.
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the alarm checker through its register bus.
// Assumes: Short millisecond and blink counts so that timeouts pass in a few cycles.
// Notes:   The far-side master is a separate model driven through its task.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import alarm_pkg::*;
	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err_led;
	logic [15:0] paddr, al_status_code;
	logic [31:0] pwdata, prdata, rd_val;
	logic [3:0]  pstrb;
	logic [2:0]  slave_state;
	logic [1:0]  port_lost = 2'b00;
	logic        eep_access_bad = 1'b0;
	logic        rd_err;
	int          err_count = 0;
	int          checks_done = 0;
	typedef struct packed {
		logic [11:0] idx; logic [31:0] val; logic [11:0] idx2; logic [31:0] val2;
		logic [15:0] code;
	} bad_cfg_s;
	// Each entry spoils one setting; the second write is harmless filler.
	bad_cfg_s bad_tab [7] = '{
		'{IBUF_START_IDX, 32'h0800, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{IBUF_START_IDX, 32'h1001, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{IBUF_LEN_IDX, 32'h000f, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{IBUF_CTRL_IDX, 32'h0004, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{MBX_IDX, 32'h1010_1008, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{OUT_BUF_IDX, 32'h0010_1008, LINK_TMO_IDX, 32'h0, CODE_SM3},
		'{CFG_IDX, 32'h0021_0010, LINK_TMO_IDX, 32'h0, CODE_RXMAP}
	};
	// ----------------------------------------------------------------
	// Clock, design and far-side master
	// ----------------------------------------------------------------
	// Free-running clock of 8 ns.
	initial begin
		forever #4 pclk = ~pclk;
	end
	alarm_checker #(.MS_CNT(4), .BLINK_CNT(8)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_lost(port_lost), .eep_access_bad(eep_access_bad), .slave_state(slave_state),
		.al_status_code(al_status_code), .err_led(err_led));
	apb_master_model master_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		master_u.xfer(1'b1, idx, d, rd_val, rd_err);
	endtask
	task automatic rd(input logic [11:0] idx);
		master_u.xfer(1'b0, idx, 32'h0, rd_val, rd_err);
	endtask
	task automatic cmd(input int n);
		wr(CMD_IDX, 32'h1 << n);
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Counts indicator rises over one whole 64-cycle pattern period of the short counts.
	task automatic cmp_led(input int exp);
		int   rises;
		logic last;
		rises = 0;
		@(negedge pclk);
		last = err_led;
		repeat (64) begin
			@(negedge pclk);
			if (err_led === 1'b1 && last === 1'b0) rises++;
			last = err_led;
		end
		checks_done++;
		if (rises != exp) begin
			err_count++;
			$display("CHECK FAILED indicator rises expected %0d seen %0d", exp, rises);
		end
	endtask
	// Waits on falling edges so the state register has settled.
	task automatic expect_state(input logic [2:0] st, input int lim);
		int i;
		for (i = 0; i < lim && slave_state !== st; i++) @(negedge pclk);
		cmp("slave state", {29'h0, st}, {29'h0, slave_state});
	endtask
	task automatic good_cfg();
		wr(IBUF_START_IDX, 32'h1000);
		wr(IBUF_LEN_IDX, 32'h0010);
		wr(IBUF_CTRL_IDX, 32'h0020);
		wr(CFG_IDX, 32'h0010_0010);
		wr(MBX_IDX, 32'h207f_2000);
		wr(OUT_BUF_IDX, 32'h0010_1800);
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		cmp_led(0);
		rd(LINK_TMO_IDX);
		cmp("timeout after reset", 32'h0, rd_val);
		rd(12'h0aa);
		cmp("unmapped error", 32'h1, {31'h0, rd_err});
		wr(LINK_TMO_IDX, 32'hffff);
		rd(LINK_TMO_IDX);
		cmp("timeout width", 32'h7fff, rd_val);
		wr(LINK_TMO_IDX, 32'h0);
		good_cfg();
		cmd(2);
		expect_state(ST_PREOP, 20);
		// Each faulty setup must hold the slave in PreOP with its code.
		foreach (bad_tab[k]) begin
			good_cfg();
			wr(bad_tab[k].idx, bad_tab[k].val);
			wr(bad_tab[k].idx2, bad_tab[k].val2);
			cmd(3);
			repeat (10) @(negedge pclk);
			cmp("fault state", {29'h0, ST_PREOP}, {29'h0, slave_state});
			cmp("fault code", {16'h0, bad_tab[k].code}, {16'h0, al_status_code});
			cmd(0);
		end
		// Oversized transmit map with a matching buffer length.
		good_cfg();
		wr(CFG_IDX, 32'h0010_0021);
		wr(IBUF_LEN_IDX, 32'h0021);
		cmd(3);
		repeat (10) @(negedge pclk);
		cmp("tx map code", {16'h0, CODE_TXMAP}, {16'h0, al_status_code});
		cmp_led(4);
		cmd(0);
		good_cfg();
		cmd(3);
		expect_state(ST_SAFEOP, 20);
		cmd(4);
		expect_state(ST_OP, 20);
		wr(IBUF_CTRL_IDX, 32'h0008);
		expect_state(ST_PREOP, 20);
		cmp("op fault code", {16'h0, CODE_SM3}, {16'h0, al_status_code});
		cmd(0);
		cmd(1);
		expect_state(ST_INIT, 20);
		// Port 0 already lost at PreOP entry is excluded; port 1 is then lost.
		wr(LINK_TMO_IDX, 32'h2);
		@(posedge pclk);
		port_lost <= 2'b01;
		repeat (6) @(posedge pclk);
		cmd(2);
		expect_state(ST_PREOP, 20);
		repeat (40) @(negedge pclk);
		cmp("excluded port", {29'h0, ST_PREOP}, {29'h0, slave_state});
		@(posedge pclk);
		port_lost <= 2'b11;
		repeat (9) @(negedge pclk);
		cmp("early link alarm", {29'h0, ST_PREOP}, {29'h0, slave_state});
		expect_state(ST_INIT, 30);
		cmp("link code", {16'h0, CODE_NONE}, {16'h0, al_status_code});
		cmp_led(2);
		@(posedge pclk);
		port_lost <= 2'b00;
		wr(LINK_TMO_IDX, 32'h0);
		cmd(0);
		cmd(2);
		expect_state(ST_PREOP, 20);
		@(posedge pclk);
		port_lost <= 2'b10;
		repeat (60) @(negedge pclk);
		cmp("disabled link", {29'h0, ST_PREOP}, {29'h0, slave_state});
		// Identity mismatch, then a clear that must not take effect.
		wr(IDENT_IDX, 32'h1234);
		expect_state(ST_INIT, 20);
		cmp("eeprom code", {16'h0, CODE_EEP}, {16'h0, al_status_code});
		cmd(0);
		rd(ALARM_IDX);
		cmp("eeprom kept", 32'h1, {31'h0, rd_val[3]});
		cmp_led(8);
		do_reset();
		wr(EEP_STATUS_IDX, 32'h1000);
		repeat (5) @(posedge pclk);
		rd(ALARM_IDX);
		cmp("eeprom status", 32'h1, {31'h0, rd_val[3]});
		do_reset();
		@(posedge pclk);
		eep_access_bad <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(ALARM_IDX);
		cmp("eeprom access", 32'h1, {31'h0, rd_val[3]});
		tally_and_finish();
	end
	// Cuts a hang short well beyond the thousand or so cycles the tests need.
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		$display("CHECK FAILED watchdog expected end seen timeout");
		tally_and_finish();
	end
endmodule
